// *** verilog/ais_consts.svh ***
`ifndef AIS_CONSTS_SVH
`define AIS_CONSTS_SVH

// register indices as printed; the byte address is four times the index
`define AIS_NUM_REGS 7
`define AIS_IDX_S1_SLOT6 8'h58
`define AIS_IDX_S1_SLOT7 8'h59
`define AIS_IDX_S1_SLOT8 8'h5A
`define AIS_IDX_S2_SLOT1 8'h5B
`define AIS_IDX_S2_SLOT2 8'h5C
`define AIS_IDX_S2_SLOT3 8'h5D
`define AIS_IDX_S2_SLOT4 8'h5E

// selection register fields and reset
`define AIS_SEL_RESET 8'h00
`define AIS_UNUSED_BIT 7
`define AIS_FIRST_HI 6
`define AIS_FIRST_LO 4
`define AIS_KIND_BIT 3
`define AIS_SECOND_HI 2
`define AIS_SECOND_LO 0

// subsample numbers covered by this bank, and the register index of its first second-sequence slot
`define AIS_S1_FIRST_SLOT 4'h6
`define AIS_S1_LAST_SLOT 4'h8
`define AIS_S2_FIRST_SLOT 4'h1
`define AIS_S2_LAST_SLOT 4'h4
`define AIS_S2_BASE_REG 4'h3

`endif

// *** verilog/ais_pkg.sv ***
package ais_pkg;

    // what the modulator input switches see for one subsample
    typedef struct packed {
        logic [2:0] first_pd;
        logic second_is_test;
        logic [2:0] second_pd;
        logic [7:0] second_test;
    } ais_route_t;

    typedef enum logic [1:0] {
        AIS_APB_IDLE = 2'b01,
        AIS_APB_ACCESS = 2'b10
    } ais_apb_state_t;

endpackage

// *** verilog/ais_sel_reg.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ais_consts.svh"

module ais_sel_reg #(
    parameter logic [7:0] RESET_VALUE = `AIS_SEL_RESET
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // write port
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    // stored value and decoded switch setting
    output logic [7:0] o_value,
    output ais_pkg::ais_route_t o_route
);

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_value <= RESET_VALUE;
        end else if (i_wr) begin
            o_value <= {1'b0, i_wdata[`AIS_FIRST_HI:0]};
        end
    end

    // a diode pattern that is not one-hot closes no diode switch, so two diodes never short together
    always_comb begin
        o_route = '0;
        if ($onehot(o_value[`AIS_FIRST_HI:`AIS_FIRST_LO])) begin
            o_route.first_pd = o_value[`AIS_FIRST_HI:`AIS_FIRST_LO];
        end
        o_route.second_is_test = o_value[`AIS_KIND_BIT];
        if (o_value[`AIS_KIND_BIT]) begin
            o_route.second_test = 8'h01 << o_value[`AIS_SECOND_HI:`AIS_SECOND_LO];
        end else if ($onehot(o_value[`AIS_SECOND_HI:`AIS_SECOND_LO])) begin
            o_route.second_pd = o_value[`AIS_SECOND_HI:`AIS_SECOND_LO];
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    property p_unused_zero;
        i_wr |=> o_value[`AIS_UNUSED_BIT] == 1'b0 && o_value[6:0] == $past(i_wdata[6:0]);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("bit 7 not zero after write");

    property p_first_pd;
        o_value[6:4] == 3'b001 |-> o_route.first_pd == 3'b001 ##1 (o_value[6:4] != 3'b100
            || o_route.first_pd[2]);
    endproperty
    a_first_pd: assert property (p_first_pd) else $error("first converter choice wrong");

    property p_kind;
        o_value[3] |-> o_route.second_pd == 3'b000 && $onehot(o_route.second_test);
    endproperty
    a_kind: assert property (p_kind) else $error("test source kind not honoured");

    property p_second_pd;
        !o_value[3] && $onehot(o_value[2:0])
            |-> o_route.second_pd == o_value[2:0] && o_route.second_test == 8'h00;
    endproperty
    a_second_pd: assert property (p_second_pd) else $error("second diode choice wrong");

    property p_test_code;
        o_value[3] && o_value[2:0] == 3'b111 |-> o_route.second_test == 8'h80;
    endproperty
    a_test_code: assert property (p_test_code) else $error("test code 111 wrong");

endmodule
`default_nettype wire

// *** verilog/ais_input_select_bank.sv ***
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "ais_consts.svh"

module ais_input_select_bank (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // sequencer position, same clock domain
    input wire logic i_seq_run,
    input wire logic i_seq_second,
    input wire logic [3:0] i_slot,
    // modulator input switch drive
    output ais_pkg::ais_route_t o_route,
    output logic o_route_valid
);

    ais_pkg::ais_apb_state_t state;
    logic [7:0] idx;
    logic addr_hit;
    logic [2:0] addr_reg;
    logic setup;
    logic access_done;
    logic [7:0] reg_value [`AIS_NUM_REGS];
    ais_pkg::ais_route_t dec [`AIS_NUM_REGS];
    logic [`AIS_NUM_REGS-1:0] wr_en;
    logic slot_hit;
    logic [2:0] slot_reg;

    // address decode: byte address is four times the register index
    assign idx = i_paddr[9:2];
    assign addr_hit = (i_paddr[11:10] == 2'b00) && (i_paddr[1:0] == 2'b00)
        && (idx >= `AIS_IDX_S1_SLOT6) && (idx <= `AIS_IDX_S2_SLOT4);
    assign addr_reg = 3'(idx - `AIS_IDX_S1_SLOT6);

    assign setup = i_psel && !i_penable;
    assign access_done = i_psel && i_penable && (state == ais_pkg::AIS_APB_ACCESS);
    assign o_pready = (state == ais_pkg::AIS_APB_ACCESS);

    // one wait-free access phase after every setup
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= ais_pkg::AIS_APB_IDLE;
        end else begin
            case (state)
                ais_pkg::AIS_APB_IDLE: begin
                    if (setup) begin
                        state <= ais_pkg::AIS_APB_ACCESS;
                    end
                end
                ais_pkg::AIS_APB_ACCESS: begin
                    if (access_done) begin
                        state <= ais_pkg::AIS_APB_IDLE;
                    end
                end
                default: begin
                    state <= ais_pkg::AIS_APB_IDLE;
                end
            endcase
        end
    end

    // read data is fetched in the setup cycle so it leaves a flop during access
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (setup) begin
            if (addr_hit && !i_pwrite) begin
                o_prdata <= {24'h00_0000, reg_value[addr_reg]};
            end else begin
                o_prdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pslverr <= 1'b0;
        end else if (setup) begin
            o_pslverr <= !addr_hit;
        end else if (access_done) begin
            o_pslverr <= 1'b0;
        end
    end

    // only the low byte lane carries a register; other lanes are ignored
    always_comb begin
        wr_en = '0;
        if (access_done && i_pwrite && addr_hit && i_pstrb[0]) begin
            wr_en[addr_reg] = 1'b1;
        end
    end

    genvar k;
    generate
        for (k = 0; k < `AIS_NUM_REGS; k++) begin : g_sel
            ais_sel_reg #(
                .RESET_VALUE(`AIS_SEL_RESET)
            ) u_ais_sel_reg (
                .i_core_clk(i_core_clk),
                .i_arst_n(i_arst_n),
                .i_wr(wr_en[k]),
                .i_wdata(i_pwdata[7:0]),
                .o_value(reg_value[k]),
                .o_route(dec[k])
            );
        end
    endgenerate

    // map the running sequencer and subsample onto one register of this bank
    always_comb begin
        slot_hit = 1'b0;
        slot_reg = 3'b000;
        if (i_seq_run) begin
            if (!i_seq_second && i_slot >= `AIS_S1_FIRST_SLOT
                && i_slot <= `AIS_S1_LAST_SLOT) begin
                slot_hit = 1'b1;
                slot_reg = 3'(i_slot - `AIS_S1_FIRST_SLOT);
            end else if (i_seq_second && i_slot >= `AIS_S2_FIRST_SLOT
                && i_slot <= `AIS_S2_LAST_SLOT) begin
                slot_hit = 1'b1;
                slot_reg = 3'(i_slot - `AIS_S2_FIRST_SLOT + `AIS_S2_BASE_REG);
            end
        end
    end

    // outside its own slots the bank opens every switch; another bank owns them then
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_route <= '0;
            o_route_valid <= 1'b0;
        end else begin
            o_route_valid <= slot_hit;
            if (slot_hit) begin
                o_route <= dec[slot_reg];
            end else begin
                o_route <= '0;
            end
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    property p_write_s2_slot1;
        access_done && i_pwrite && addr_hit && i_pstrb[0] && idx == `AIS_IDX_S2_SLOT1
            |=> reg_value[3] == {1'b0, $past(i_pwdata[6:0])};
    endproperty
    a_write_s2_slot1: assert property (p_write_s2_slot1) else $error("write at 0x5B missed");

    property p_write_s1_slot6;
        access_done && i_pwrite && i_pstrb[0] && i_paddr == 12'h0160
            |=> reg_value[0] == {1'b0, $past(i_pwdata[6:0])};
    endproperty
    a_write_s1_slot6: assert property (p_write_s1_slot6) else $error("write at 0x58 missed");

    property p_read_back;
        setup && addr_hit && !i_pwrite
            |=> o_pready && !o_pslverr && o_prdata[31:7] == 25'h000_0000
                && o_prdata[6:0] == $past(reg_value[addr_reg][6:0]);
    endproperty
    a_read_back: assert property (p_read_back) else $error("read back wrong");

    property p_unmapped;
        setup && !addr_hit |=> o_pready && o_pslverr && o_prdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

    property p_route_s1_slot7;
        i_seq_run && !i_seq_second && i_slot == 4'h7
            |=> o_route_valid && o_route == $past(dec[1]);
    endproperty
    a_route_s1_slot7: assert property (p_route_s1_slot7) else $error("slot 7 route wrong");

    property p_route_s2_slot4;
        i_seq_run && i_seq_second && i_slot == 4'h4
            |=> o_route_valid && o_route == $past(dec[6]);
    endproperty
    a_route_s2_slot4: assert property (p_route_s2_slot4) else $error("slot 4 route wrong");

    property p_route_idle;
        !i_seq_run || (!i_seq_second && i_slot == 4'h5) |=> !o_route_valid && o_route == '0;
    endproperty
    a_route_idle: assert property (p_route_idle) else $error("route driven off slot");

    property p_first_follows_reg;
        i_seq_run && i_seq_second && i_slot == 4'h1 && reg_value[3][6:4] == 3'b010
            |=> o_route.first_pd == 3'b010;
    endproperty
    a_first_follows_reg: assert property (p_first_follows_reg) else $error("diode two lost");

    property p_test_mode;
        i_seq_run && !i_seq_second && i_slot == 4'h8 && reg_value[2][3:0] == 4'b1011
            |=> o_route.second_is_test && o_route.second_test == 8'h08
                && o_route.second_pd == 3'b000;
    endproperty
    a_test_mode: assert property (p_test_mode) else $error("test code 011 wrong");

    property p_pready_once;
        setup && state == ais_pkg::AIS_APB_IDLE |=> o_pready ##1 !o_pready;
    endproperty
    a_pready_once: assert property (p_pready_once) else $error("pready not one cycle");

    // every slot of this bank routes its own register
    property p_route_s1_slot6;
        i_seq_run && !i_seq_second && i_slot == 4'h6
            |=> o_route_valid && o_route == $past(dec[0]);
    endproperty
    a_route_s1_slot6: assert property (p_route_s1_slot6) else $error("route 1-6 wrong");

    property p_route_s1_slot8;
        i_seq_run && !i_seq_second && i_slot == 4'h8
            |=> o_route_valid && o_route == $past(dec[2]);
    endproperty
    a_route_s1_slot8: assert property (p_route_s1_slot8) else $error("route 1-8 wrong");

    property p_route_s2_slot1;
        i_seq_run && i_seq_second && i_slot == 4'h1
            |=> o_route_valid && o_route == $past(dec[3]);
    endproperty
    a_route_s2_slot1: assert property (p_route_s2_slot1) else $error("route 2-1 wrong");

    property p_route_s2_slot2;
        i_seq_run && i_seq_second && i_slot == 4'h2
            |=> o_route_valid && o_route == $past(dec[4]);
    endproperty
    a_route_s2_slot2: assert property (p_route_s2_slot2) else $error("route 2-2 wrong");

    property p_route_s2_slot3;
        i_seq_run && i_seq_second && i_slot == 4'h3
            |=> o_route_valid && o_route == $past(dec[5]);
    endproperty
    a_route_s2_slot3: assert property (p_route_s2_slot3) else $error("route 2-3 wrong");

    // slots of the other banks must leave every switch open
    property p_route_foreign;
        i_seq_run && (i_seq_second ? (i_slot == 4'h0 || i_slot > 4'h4)
            : (i_slot < 4'h6 || i_slot > 4'h8)) |=> !o_route_valid && o_route == '0;
    endproperty
    a_route_foreign: assert property (p_route_foreign) else $error("foreign slot routed");

    // without the low strobe a write must leave the byte alone
    property p_no_strobe;
        access_done && i_pwrite && !i_pstrb[0] && idx == `AIS_IDX_S2_SLOT1
            |=> reg_value[3] == $past(reg_value[3]);
    endproperty
    a_no_strobe: assert property (p_no_strobe) else $error("write without strobe landed");

    // the upper address bits are decoded, so an alias of the first register is refused
    property p_alias_refused;
        access_done && i_pwrite && !addr_hit && idx == `AIS_IDX_S1_SLOT6
            |=> reg_value[0] == $past(reg_value[0]);
    endproperty
    a_alias_refused: assert property (p_alias_refused) else $error("alias write landed");

    property p_read_keeps;
        access_done && !i_pwrite && idx == `AIS_IDX_S1_SLOT8
            |=> reg_value[2] == $past(reg_value[2]);
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("read changed a register");

    property p_err_clears;
        access_done |=> !o_pslverr;
    endproperty
    a_err_clears: assert property (p_err_clears) else $error("error flag stuck");

    // write transfers return zero read data, so stale read data never leaks
    property p_write_rdata;
        setup && i_pwrite |=> o_pready && o_prdata == 32'h0000_0000;
    endproperty
    a_write_rdata: assert property (p_write_rdata) else $error("read data on a write");

    property p_write_ok;
        setup && i_pwrite && addr_hit |=> o_pready && !o_pslverr;
    endproperty
    a_write_ok: assert property (p_write_ok) else $error("mapped write refused");

    property p_write_s2_slot4;
        access_done && i_pwrite && i_pstrb[0] && i_paddr == 12'h0178
            |=> reg_value[6] == {1'b0, $past(i_pwdata[6:0])};
    endproperty
    a_write_s2_slot4: assert property (p_write_s2_slot4) else $error("write at 0x5E lost");

    c_write: cover property (access_done && i_pwrite && addr_hit);
    c_read: cover property (access_done && !i_pwrite && addr_hit);
    c_unmapped: cover property (access_done && o_pslverr);
    c_route_test: cover property (o_route_valid && o_route.second_is_test);
    c_alias: cover property (access_done && !addr_hit && idx == `AIS_IDX_S1_SLOT6);

endmodule
`default_nettype wire

// *** verification/ais_input_select_bank_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ais_consts.svh"

module ais_input_select_bank_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic run = 1'b0;
    logic sec = 1'b0;
    logic [3:0] slot = 4'h0;
    logic pready;
    logic pslverr;
    logic rvalid;
    logic [31:0] prdata;
    ais_pkg::ais_route_t route;
    logic [7:0] shadow [7];
    logic [31:0] xs = 32'h0000_0013;
    int err_total = 0;
    int compares = 0;

    always #2 clk = ~clk;

    ais_input_select_bank u_ais_input_select_bank (
        .i_core_clk(clk),
        .i_arst_n(arst_n),
        .i_psel(psel),
        .i_penable(penable),
        .i_pwrite(pwrite),
        .i_paddr(paddr),
        .i_pwdata(pwdata),
        .i_pstrb(pstrb),
        .o_pready(pready),
        .o_prdata(prdata),
        .o_pslverr(pslverr),
        .i_seq_run(run),
        .i_seq_second(sec),
        .i_slot(slot),
        .o_route(route),
        .o_route_valid(rvalid)
    );

    function logic [31:0] rnd();
        xs = xs ^ (xs << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
        return xs;
    endfunction

    // switch setting expected for one selection byte
    function automatic ais_pkg::ais_route_t dec(input logic [7:0] v);
        ais_pkg::ais_route_t r;
        r = '0;
        if ($onehot(v[6:4])) r.first_pd = v[6:4];
        r.second_is_test = v[3];
        if (v[3]) r.second_test = 8'h01 << v[2:0];
        else if ($onehot(v[2:0])) r.second_pd = v[2:0];
        return r;
    endfunction

    function automatic logic [11:0] ad(input int i);
        return 12'((int'(`AIS_IDX_S1_SLOT6) + i) * 4);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // one apb transfer; the answer is awaited, never assumed
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        int n;
        int i;
        logic ok;
        logic [31:0] rd;
        logic er;
        n = 0;
        i = int'(a >> 2) - int'(`AIS_IDX_S1_SLOT6);
        ok = a[11:10] == 2'h0 && a[1:0] == 2'h0 && i >= 0 && i < 7;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= wr ? s : 4'h0;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, pready}, 32'h1);
        chk(32'(n), 32'h1);
        chk({31'h0, er}, {31'h0, !ok});
        if (wr && ok && s[0]) shadow[i] = d[7:0] & 8'h7F;
        if (!wr) chk(rd, ok ? {24'h0, shadow[i]} : 32'h0);
    endtask

    task automatic seqchk(input logic r, input logic s2, input logic [3:0] sl);
        int i;
        i = s2 ? int'(sl) + 2 : int'(sl) - 6;
        if (!r || (s2 && (sl < 4'h1 || sl > 4'h4)) || (!s2 && (sl < 4'h6 || sl > 4'h8))) i = -1;
        @(posedge clk);
        run <= r;
        sec <= s2;
        slot <= sl;
        @(posedge clk);
        #1;
        chk({31'h0, rvalid}, {31'h0, i >= 0});
        chk(32'(route), i >= 0 ? 32'(dec(shadow[i])) : 32'h0);
    endtask

    task automatic sweep();
        for (int k = 0; k < 64; k++) seqchk(k[5], k[4], k[3:0]);
        for (int k = 0; k < 7; k++) xfer(1'b0, ad(k), 32'h0, 4'h0);
    endtask

    task automatic reset_dut();
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        for (int k = 0; k < 7; k++) shadow[k] = 8'h00;
    endtask

    initial begin
        logic [31:0] r;
        logic [11:0] bad [4];
        bad = '{12'h15C, 12'h17C, 12'h162, 12'h960};
        reset_dut();
        sweep();
        // every byte value, so every one-hot and coded source is routed at least once
        for (int v = 0; v < 256; v++) begin
            xfer(1'b1, ad(v % 7), 32'(v) | (rnd() & 32'hFFFF_FF00), 4'h1);
            seqchk(1'b1, v % 7 > 2, v % 7 > 2 ? 4'(v % 7 - 2) : 4'(v % 7 + 6));
        end
        sweep();
        // refused places and a write without the low strobe
        foreach (bad[k]) begin
            xfer(1'b1, bad[k], 32'hFFFF_FFFF, 4'hF);
            xfer(1'b0, bad[k], 32'h0, 4'h0);
        end
        xfer(1'b1, ad(3), 32'h0000_0055, 4'hE);
        sweep();
        repeat (60) begin
            r = rnd();
            xfer(r[5], r[3:0] == 4'h0 ? r[31:20] : ad(int'(r[10:8]) % 7), rnd(), r[19:16]);
        end
        sweep();
        // reset in mid-run clears every selection
        reset_dut();
        sweep();
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire
